// file: src/tbu_xact_defs.svh
// constants for the transaction type filter of the translation buffer unit
`ifndef TBU_XACT_DEFS_SVH
`define TBU_XACT_DEFS_SVH

// field widths
`define ADDR_W 48
`define SID_W 24
`define ID_W 8
`define STASH_W 18
`define ATOP_W 6

// memory type: normal write-back, read and write allocate
`define CACHE_WB_RWA 4'hf

// shareability domain codes
`define DOM_NONSH 2'h0
`define DOM_INNER 2'h1
`define DOM_OUTER 2'h2
`define DOM_SYS 2'h3

// snoop code of a plain non-snooping write
`define SNOOP_PLAIN 4'h0

// write and read response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// protection bits kept for a translation prefetch (bit 1 only)
`define PROT_SPEC_MASK 3'h2

`endif

// file: src/tbu_xact_pkg.sv
// types shared by the transaction type filter modules
`default_nettype none

package tbu_xact_pkg;

    // transaction kinds seen on the upstream and downstream ports
    typedef enum logic [4:0] {
        OP_READ,
        OP_WRITE,
        OP_WRITE_NOSNOOP,
        OP_WRITE_LINE_UNIQUE,
        OP_ATOMIC,
        OP_CLEAN_SHARED,
        OP_CLEAN_INVALID,
        OP_MAKE_INVALID,
        OP_CLEAN_SHARED_PERSIST,
        OP_RO_MAKE_INVALID,
        OP_RO_CLEAN_INVALID,
        OP_WU_PTL_STASH,
        OP_WU_FULL_STASH,
        OP_STASH_ONCE_SHARED,
        OP_STASH_ONCE_UNIQUE,
        OP_STASH_TRANSLATION
    } op_t;

    // translation result presented with each transaction
    typedef struct packed {
        logic perm_r;                        // read permission
        logic perm_w;                        // write permission
        logic perm_x;                        // execute permission
        logic destructive_read_permission;   // invalidate may stay
        logic cache_prefetch_permission;     // stash allowed
        logic stream_off_response;           // stream disabled
        logic global_off_response;           // translation globally off
        logic [3:0] cache;                   // translated memory type
        logic [1:0] dom;                     // translated shareability
    } xlate_t;

endpackage

`default_nettype wire

// file: src/decide_if.sv
// decision bundle between the filter top and its type decider
`default_nettype none

interface decide_if;
    import tbu_xact_pkg::*;

    op_t op;          // upstream transaction kind
    xlate_t xl;       // translation result
    logic fin_shwb;   // final attributes shareable write-back
    logic fin_sh;     // final domain inner or outer
    op_t out_op;      // downstream transaction kind
    logic fault;      // translation fault
    logic local_end;  // completed inside the unit
    logic stash_zero; // stash fields forced to zero
    logic spec;       // translation request is speculative
    logic pf;         // prefetch into main translation cache
    logic cmo_attr;   // memory attributes replaced
    logic is_write;   // write-channel transaction

    modport decider (input op, xl, fin_shwb, fin_sh,
        output out_op, fault, local_end, stash_zero, spec, pf, cmo_attr,
        is_write);
    modport user (output op, xl, fin_shwb, fin_sh,
        input out_op, fault, local_end, stash_zero, spec, pf, cmo_attr,
        is_write);
endinterface

`default_nettype wire

// file: src/xact_decider.sv
// decides fault, conversion and local termination per transaction
`default_nettype none

module xact_decider
(
    decide_if.decider d // decision bundle
);
    import tbu_xact_pkg::*;

    // class decode of the incoming kind
    wire cmo_rd = d.op inside {OP_CLEAN_SHARED, OP_CLEAN_INVALID,
        OP_MAKE_INVALID, OP_CLEAN_SHARED_PERSIST, OP_RO_MAKE_INVALID,
        OP_RO_CLEAN_INVALID};
    wire wr_stash = d.op inside {OP_WU_PTL_STASH, OP_WU_FULL_STASH};
    wire once = d.op inside {OP_STASH_ONCE_SHARED, OP_STASH_ONCE_UNIQUE};
    wire st_tr = d.op == OP_STASH_TRANSLATION;
    wire nofault = once | st_tr;
    wire need_rd = cmo_rd | (d.op == OP_READ);
    wire need_wr = wr_stash | (d.op inside {OP_WRITE, OP_WRITE_NOSNOOP,
        OP_WRITE_LINE_UNIQUE, OP_ATOMIC});
    // permission and disable terms
    wire rd_ok = d.xl.perm_r | d.xl.perm_x;
    wire perm_ok = need_rd ? rd_ok : (need_wr ? d.xl.perm_w : 1'b1);
    wire off = d.xl.stream_off_response | d.xl.global_off_response;
    wire any_perm = d.xl.perm_r | d.xl.perm_w | d.xl.perm_x;
    wire keep_inv = d.xl.perm_w & d.xl.destructive_read_permission;
    wire pf_ok = d.xl.cache_prefetch_permission;
    // stash once ends locally, disabled streams included
    wire once_end = once & (off | !pf_ok | !d.fin_shwb | !any_perm);

    assign d.fault = !nofault & (off | !perm_ok);
    assign d.local_end = d.fault | once_end | st_tr;
    assign d.stash_zero = wr_stash & (!pf_ok | !d.fin_shwb);
    assign d.spec = nofault;
    assign d.pf = st_tr & !off;
    assign d.cmo_attr = d.op inside {OP_CLEAN_SHARED, OP_CLEAN_INVALID,
        OP_MAKE_INVALID, OP_CLEAN_SHARED_PERSIST};
    assign d.is_write = need_wr | once | st_tr;

    // downstream kind, same as upstream unless converted
    always_comb
    begin
        d.out_op = d.op;
        unique case (d.op)
            OP_MAKE_INVALID:
                d.out_op = keep_inv ? OP_MAKE_INVALID
                    : OP_CLEAN_INVALID;
            OP_RO_MAKE_INVALID:
                d.out_op = !d.fin_shwb ? OP_READ
                    : (keep_inv ? OP_RO_MAKE_INVALID
                    : OP_RO_CLEAN_INVALID);
            OP_RO_CLEAN_INVALID:
                d.out_op = d.fin_shwb ? OP_RO_CLEAN_INVALID
                    : OP_READ;
            OP_WU_PTL_STASH, OP_WU_FULL_STASH:
                d.out_op = d.stash_zero ? OP_WRITE : d.op;
            OP_WRITE_LINE_UNIQUE:
                d.out_op = d.fin_sh ? d.op : OP_WRITE_NOSNOOP;
            default:
                d.out_op = d.op;
        endcase
    end
endmodule

`default_nettype wire

// file: src/tbu_transaction_type_filter.sv
// transaction type filter between upstream and downstream ports
`include "tbu_xact_defs.svh"
`default_nettype none

// Behaviour
// - forward upstream transaction kind unchanged by default
// - non-shareable WriteLineUnique becomes WriteNoSnoop, snoop zero
// - cache maintenance and read-once kinds need read/execute
// - unique stash writes need write permission
// - maintenance ops get normal write-back allocate attributes
// - MakeInvalid becomes CleanInvalid without write plus destructive
// - ReadOnceMakeInvalid becomes ReadOnceCleanInvalid likewise
// - read-once invalidates become plain reads unless shareable WB
// - stash writes plain unless prefetch and shareable WB
// - downgraded stash writes drive stash fields zero
// - stash once and translation kinds never fault
// - their translation requests are speculative
// - stash once ends locally with OKAY unless permitted
// - any one of read, write, execute permits stash
// - disabled-stream stash once still answers OKAY
// - translation stash never forwarded, only prefetches
// - translation stash always answered OKAY
// - translation stash ignores protection bits zero and two
// - ports carry wakeup, atomic and stash fields
module tbu_transaction_type_filter
(
    input wire logic mclk,                          // core clock
    input wire logic arst_n,                        // async reset
    // upstream_slave_port request with its translation result
    input wire logic req_valid,                     // request present
    output logic req_ready,                         // request taken
    input wire tbu_xact_pkg::op_t req_op,           // transaction kind
    input wire logic [`ID_W-1:0] req_id,            // transaction id
    input wire logic [`SID_W-1:0] req_sid,          // stream id
    input wire logic [3:0] req_snoop,               // snoop code
    input wire logic [2:0] req_prot,                // protection
    input wire logic [`STASH_W-1:0] req_stash,      // stash fields
    input wire logic [`ATOP_W-1:0] req_atop,        // atomic opcode
    input wire logic req_wakeup,                    // wakeup level
    input wire tbu_xact_pkg::xlate_t xl,            // translation
    input wire logic [`ADDR_W-1:0] xl_addr,         // output address
    // translation_request_link qualifiers
    output logic tr_spec,                           // speculative
    output logic [2:0] tr_prot,                     // request prot
    // downstream_master_port request
    output logic dn_valid,                          // request present
    input wire logic dn_ready,                      // request taken
    output tbu_xact_pkg::op_t dn_op,                // transaction kind
    output logic [`ID_W-1:0] dn_id,                 // transaction id
    output logic [`ADDR_W-1:0] dn_addr,             // address
    output logic [3:0] dn_snoop,                    // snoop code
    output logic [3:0] dn_cache,                    // memory type
    output logic [1:0] dn_dom,                      // shareability
    output logic [2:0] dn_prot,                     // protection
    output logic [`STASH_W-1:0] dn_stash,           // stash fields
    output logic [`ATOP_W-1:0] dn_atop,             // atomic opcode
    output logic dn_wakeup,                         // wakeup level
    // local completion toward upstream
    output logic done_valid,                        // response present
    input wire logic done_ready,                    // response taken
    output logic done_write,                        // write response
    output logic [`ID_W-1:0] done_id,               // transaction id
    output logic [1:0] done_resp,                   // response code
    // fault report and prefetch notice
    output logic fault_valid,                       // fault pulse
    output logic [`SID_W-1:0] fault_sid,            // faulting stream
    output logic pf_valid,                          // prefetch pulse
    output logic [`SID_W-1:0] pf_sid                // prefetch stream
);
    import tbu_xact_pkg::*;

    // decision bundle and its decider
    decide_if dif();

    xact_decider u_decider
    (
        .d(dif)
    );

    // final attribute selection
    wire [1:0] fin_dom; // final shareability
    wire [3:0] fin_cache; // final memory type
    wire fin_wb; // final memory type write-back
    wire fin_sh; // final domain inner or outer

    // maintenance ops are never system shareable
    assign fin_dom = (dif.cmo_attr && xl.dom == `DOM_SYS) ? `DOM_OUTER
        : xl.dom;
    assign fin_cache = dif.cmo_attr ? `CACHE_WB_RWA : xl.cache;
    // modifiable, bufferable and some allocate hint marks write-back
    assign fin_wb = fin_cache[1] & fin_cache[0]
        & (fin_cache[3] | fin_cache[2]);
    assign fin_sh = (fin_dom == `DOM_INNER) || (fin_dom == `DOM_OUTER);

    // feed the decider
    assign dif.op = req_op;
    assign dif.xl = xl;
    assign dif.fin_shwb = fin_wb & fin_sh;
    assign dif.fin_sh = fin_sh;

    // translation request qualifiers
    assign tr_spec = req_valid & dif.spec;
    assign tr_prot = (req_op == OP_STASH_TRANSLATION)
        ? (req_prot & `PROT_SPEC_MASK) : req_prot;

    // output slot state
    logic dn_valid_q; // downstream slot full
    logic done_valid_q; // completion slot full
    wire dn_free = !dn_valid_q | dn_ready; // slot may be loaded
    wire done_free = !done_valid_q | done_ready; // slot may be loaded

    // steer the request to the slot it needs
    assign req_ready = dif.local_end ? done_free : dn_free;
    wire accept = req_valid & req_ready; // request taken this edge
    wire take_dn = accept & !dif.local_end;
    wire take_done = accept & dif.local_end;

    // downstream field values
    wire [3:0] snoop_out = (dif.out_op == OP_WRITE_NOSNOOP)
        ? `SNOOP_PLAIN : req_snoop;
    wire [`STASH_W-1:0] stash_out = dif.stash_zero
        ? {`STASH_W{1'b0}} : req_stash;
    wire [1:0] resp_out = dif.fault ? `RESP_SLVERR : `RESP_OKAY;

    // downstream payload registers
    op_t dn_op_q; // downstream kind
    logic [`ID_W-1:0] dn_id_q; // downstream id
    logic [`ADDR_W-1:0] dn_addr_q; // downstream address
    logic [3:0] dn_snoop_q; // downstream snoop
    logic [3:0] dn_cache_q; // downstream memory type
    logic [1:0] dn_dom_q; // downstream shareability
    logic [2:0] dn_prot_q; // downstream protection
    logic [`STASH_W-1:0] dn_stash_q; // downstream stash fields
    logic [`ATOP_W-1:0] dn_atop_q; // downstream atomic opcode
    logic dn_wakeup_q; // downstream wakeup

    // completion registers
    logic done_write_q; // write or read response
    logic [`ID_W-1:0] done_id_q; // response id
    logic [1:0] done_resp_q; // response code

    // report registers
    logic fault_q; // fault pulse
    logic [`SID_W-1:0] fault_sid_q; // fault stream
    logic pf_q; // prefetch pulse
    logic [`SID_W-1:0] pf_sid_q; // prefetch stream

    // downstream slot valid
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            dn_valid_q <= 1'b0;
        else if (dn_free)
            dn_valid_q <= take_dn;
    end

    // downstream payload, loaded with each forwarded request
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dn_op_q <= OP_READ;
            dn_id_q <= '0;
            dn_addr_q <= '0;
            dn_snoop_q <= 4'h0;
            dn_cache_q <= 4'h0;
            dn_dom_q <= 2'h0;
            dn_prot_q <= 3'h0;
            dn_stash_q <= '0;
            dn_atop_q <= '0;
        end
        else if (take_dn)
        begin
            dn_op_q <= dif.out_op;
            dn_id_q <= req_id;
            dn_addr_q <= xl_addr;
            dn_snoop_q <= snoop_out;
            dn_cache_q <= fin_cache;
            dn_dom_q <= fin_dom;
            dn_prot_q <= req_prot;
            dn_stash_q <= stash_out;
            dn_atop_q <= req_atop;
        end
    end

    // wakeup level passes straight through one flop
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            dn_wakeup_q <= 1'b0;
        else
            dn_wakeup_q <= req_wakeup;
    end

    // completion slot valid
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            done_valid_q <= 1'b0;
        else if (done_free)
            done_valid_q <= take_done;
    end

    // completion payload
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_write_q <= 1'b0;
            done_id_q <= '0;
            done_resp_q <= 2'h0;
        end
        else if (take_done)
        begin
            done_write_q <= dif.is_write;
            done_id_q <= req_id;
            done_resp_q <= resp_out;
        end
    end

    // fault and prefetch pulses
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_q <= 1'b0;
            pf_q <= 1'b0;
        end
        else
        begin
            fault_q <= accept & dif.fault;
            pf_q <= accept & dif.pf;
        end
    end

    // stream ids that go with the pulses
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_sid_q <= '0;
            pf_sid_q <= '0;
        end
        else if (accept)
        begin
            fault_sid_q <= req_sid;
            pf_sid_q <= req_sid;
        end
    end

    // outputs straight from the registers
    assign dn_valid = dn_valid_q;
    assign dn_op = dn_op_q;
    assign dn_id = dn_id_q;
    assign dn_addr = dn_addr_q;
    assign dn_snoop = dn_snoop_q;
    assign dn_cache = dn_cache_q;
    assign dn_dom = dn_dom_q;
    assign dn_prot = dn_prot_q;
    assign dn_stash = dn_stash_q;
    assign dn_atop = dn_atop_q;
    assign dn_wakeup = dn_wakeup_q;
    assign done_valid = done_valid_q;
    assign done_write = done_write_q;
    assign done_id = done_id_q;
    assign done_resp = done_resp_q;
    assign fault_valid = fault_q;
    assign fault_sid = fault_sid_q;
    assign pf_valid = pf_q;
    assign pf_sid = pf_sid_q;

    // checks on the conversion, stall hold and wakeup behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    wire off_in = xl.stream_off_response | xl.global_off_response;

    plain_read_keep_a: assert property (
        take_dn && req_op == OP_READ |=> dn_valid && dn_op == OP_READ)
        else $error("plain read kind changed");

    wlu_nosnoop_a: assert property (
        take_dn && req_op == OP_WRITE_LINE_UNIQUE && !fin_sh
        |=> dn_op == OP_WRITE_NOSNOOP && dn_snoop == `SNOOP_PLAIN)
        else $error("WriteLineUnique not turned into WriteNoSnoop");

    cmo_read_perm_a: assert property (
        accept && req_op == OP_CLEAN_INVALID && !off_in
        && !xl.perm_r && !xl.perm_x
        |=> done_valid && done_resp == `RESP_SLVERR && fault_valid)
        else $error("maintenance op passed without read permission");

    stash_wr_perm_a: assert property (
        accept && req_op == OP_WU_FULL_STASH && !xl.perm_w
        |=> fault_valid && !$past(take_dn))
        else $error("stash write passed without write permission");

    cmo_attr_a: assert property (
        take_dn && req_op == OP_CLEAN_SHARED
        |=> dn_cache == `CACHE_WB_RWA && dn_dom != `DOM_SYS)
        else $error("maintenance attributes not replaced");

    make_inv_a: assert property (
        take_dn && req_op == OP_MAKE_INVALID
        && !(xl.perm_w && xl.destructive_read_permission)
        |=> dn_op == OP_CLEAN_INVALID)
        else $error("MakeInvalid kept without destructive permission");

    ro_inv_a: assert property (
        take_dn && req_op == OP_RO_MAKE_INVALID && dif.fin_shwb
        && !xl.perm_w |=> dn_op == OP_RO_CLEAN_INVALID)
        else $error("read-once invalidate kept without permission");

    ro_plain_a: assert property (
        take_dn && req_op inside {OP_RO_MAKE_INVALID, OP_RO_CLEAN_INVALID}
        && !dif.fin_shwb |=> dn_op == OP_READ)
        else $error("read-once invalidate not made a plain read");

    stash_plain_a: assert property (
        take_dn && req_op == OP_WU_PTL_STASH
        && !xl.cache_prefetch_permission
        |=> dn_op == OP_WRITE && dn_stash == '0)
        else $error("stash write not downgraded with stash zero");

    stash_no_fault_a: assert property (
        accept && req_op inside {OP_STASH_ONCE_SHARED,
        OP_STASH_ONCE_UNIQUE, OP_STASH_TRANSLATION} |=> !fault_valid)
        else $error("stash transaction raised a fault");

    spec_req_a: assert property (
        req_valid && req_op == OP_STASH_ONCE_UNIQUE |-> tr_spec)
        else $error("stash translation request not speculative");

    once_end_a: assert property (
        accept && req_op == OP_STASH_ONCE_SHARED
        && (off_in || !(xl.perm_r || xl.perm_w || xl.perm_x))
        |=> done_valid && done_write && done_resp == `RESP_OKAY)
        else $error("stash once not ended locally with OKAY");

    xlate_local_a: assert property (
        accept && req_op == OP_STASH_TRANSLATION
        |=> done_valid && done_resp == `RESP_OKAY
        && !($rose(dn_valid)))
        else $error("translation stash forwarded or not OKAY");

    prot_mask_a: assert property (
        req_op == OP_STASH_TRANSLATION |-> tr_prot[0] == 1'b0
        && tr_prot[2] == 1'b0 && tr_prot[1] == req_prot[1])
        else $error("translation stash protection not masked");

    dn_hold_a: assert property (
        dn_valid && !dn_ready |=> dn_valid && $stable(dn_op)
        && $stable(dn_addr) && $stable(dn_id))
        else $error("downstream request changed while stalled");

    wakeup_pass_a: assert property (
        dn_wakeup == $past(req_wakeup))
        else $error("wakeup level not passed downstream");
endmodule

`default_nettype wire

// file: sim/dn_sink.sv
// downstream interconnect model that accepts requests with random stalls
`default_nettype none

module dn_sink
(
    input wire logic mclk,     // core clock
    input wire logic arst_n,   // async reset
    input wire logic dn_valid, // request present
    output logic dn_ready      // request accepted
);
    timeunit 1ns;
    timeprecision 1ps;

    // stall about one cycle in three while a request waits
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            dn_ready <= 1'b0;
        else
            dn_ready <= dn_valid ? ($urandom_range(0, 2) != 0) : 1'b1;
    end
endmodule

`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the transaction type filter
`default_nettype none

module tb;
    import tbu_xact_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, done_ready = 1'b0;
    logic req_ready, tr_spec, dn_valid, dn_ready, done_valid, done_write;
    logic dn_wakeup, fault_valid, pf_valid, req_wakeup = 1'b0;
    op_t req_op = OP_READ;
    op_t dn_op;
    xlate_t xl = '0;
    logic [7:0] req_id = 8'h0, dn_id, done_id;
    logic [23:0] req_sid = 24'h0, fault_sid, pf_sid;
    logic [3:0] req_snoop = 4'h0, dn_snoop, dn_cache;
    logic [2:0] req_prot = 3'h0, tr_prot, dn_prot;
    logic [17:0] req_stash = 18'h0, dn_stash;
    logic [47:0] xl_addr = 48'h0, dn_addr;
    logic [1:0] dn_dom, done_resp;
    logic [5:0] req_atop = 6'h0, dn_atop;
    logic [33:0] q_dn[$], q_done[$]; // expected results per exit
    logic [23:0] q_flt[$], q_pf[$]; // expected stream ids of pulses
    int n_fail = 0, checked = 0;

    tbu_transaction_type_filter dut (.*);
    dn_sink sink (.*);

    // free-running core clock
    initial forever #2 mclk = ~mclk;

    // completion side stalls now and then
    always @(posedge mclk) done_ready <= ($urandom_range(0, 3) != 0);

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(logic [33:0] got, logic [33:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // expected {kind, resp, stash kept, snoop, cache}; dn says which exit
    function automatic logic [15:0] expv(op_t o, xlate_t x, logic [3:0] sn,
        output logic dn, output logic wr);
        logic sh, shwb, off, okp, st;
        op_t q;
        sh = (x.dom == 2'h1 || x.dom == 2'h2);
        shwb = sh & x.cache[1] & x.cache[0] & (x.cache[3] | x.cache[2]);
        off = x.stream_off_response | x.global_off_response;
        okp = x.perm_r | x.perm_w | x.perm_x;
        dn = 1'b0;
        wr = !(o inside {OP_READ, OP_CLEAN_SHARED, OP_CLEAN_INVALID,
            OP_MAKE_INVALID, OP_CLEAN_SHARED_PERSIST, OP_RO_MAKE_INVALID,
            OP_RO_CLEAN_INVALID});
        q = o;
        st = 1'b1;
        if (o == OP_STASH_TRANSLATION) return 16'h0;
        if (o inside {OP_STASH_ONCE_SHARED, OP_STASH_ONCE_UNIQUE})
        begin
            dn = !off & x.cache_prefetch_permission & shwb & okp;
            return dn ? {o, 2'h0, st, sn, x.cache} : 16'h0;
        end
        okp = wr ? x.perm_w : x.perm_r | x.perm_x;
        if (off | !okp) return {5'h0, 2'h2, 9'h0};
        okp = x.perm_w & x.destructive_read_permission;
        if (o == OP_MAKE_INVALID && !okp) q = OP_CLEAN_INVALID;
        if (o == OP_RO_MAKE_INVALID && !okp) q = OP_RO_CLEAN_INVALID;
        if (q inside {OP_RO_MAKE_INVALID, OP_RO_CLEAN_INVALID} && !shwb)
            q = OP_READ;
        if (o inside {OP_WU_PTL_STASH, OP_WU_FULL_STASH}
            && !(x.cache_prefetch_permission & shwb))
        begin
            q = OP_WRITE;
            st = 1'b0;
        end
        if (o == OP_WRITE_LINE_UNIQUE && !sh) q = OP_WRITE_NOSNOOP;
        dn = 1'b1;
        return {q, 2'h0, st, (q == OP_WRITE_NOSNOOP) ? 4'h0 : sn,
            (o inside {OP_CLEAN_SHARED, OP_CLEAN_INVALID, OP_MAKE_INVALID,
            OP_CLEAN_SHARED_PERSIST}) ? 4'hf : x.cache};
    endfunction

    // present one request, hold it until taken, note its expectation
    task automatic send(op_t o, xlate_t x);
        logic [15:0] e;
        logic d, sp, wr;
        logic [3:0] sn;
        logic [2:0] pr;
        logic [5:0] at;
        logic [23:0] sd;
        int i;
        sn = 4'($urandom);
        pr = 3'($urandom);
        at = 6'($urandom);
        sd = {22'h0, 2'($urandom)};
        sp = o inside {OP_STASH_ONCE_SHARED, OP_STASH_ONCE_UNIQUE,
            OP_STASH_TRANSLATION};
        e = expv(o, x, sn, d, wr);
        req_valid <= 1'b1;
        req_op <= o;
        xl <= x;
        req_snoop <= sn;
        req_prot <= pr;
        req_stash <= 18'($urandom) | 18'h1;
        req_id <= 8'($urandom);
        req_sid <= sd;
        req_atop <= at;
        req_wakeup <= 1'($urandom);
        xl_addr <= {$urandom, 16'h0};
        for (i = 0; i < 100; i++)
        begin
            @(negedge mclk);
            cmp({30'h0, tr_spec, tr_prot}, {30'h0, sp,
                (o == OP_STASH_TRANSLATION) ? pr & 3'h2 : pr});
            if (req_ready === 1'b1) break;
            @(posedge mclk);
        end
        if (i == 100)
        begin
            n_fail++;
            test_done;
        end
        @(posedge mclk);
        if (d) q_dn.push_back({req_id, 1'b0, pr, at, e});
        else q_done.push_back({req_id, wr, 9'h0, e});
        if (!d && e[10:9] == 2'h2) q_flt.push_back(sd);
        if (o == OP_STASH_TRANSLATION && !x.stream_off_response
            && !x.global_off_response) q_pf.push_back(sd);
    endtask

    // release the request line and wait for every result to come out
    task automatic end_test(string name);
        int i;
        req_valid <= 1'b0;
        for (i = 0; i < 300 && (q_dn.size() + q_done.size() + q_flt.size()
            + q_pf.size()) > 0; i++)
            @(posedge mclk);
        if (i < 300)
            $display("test %s finished", name);
        else
        begin
            n_fail++;
            test_done;
        end
    endtask

    // compare each result as it leaves either exit
    always @(posedge mclk)
    begin
        if (dn_valid === 1'b1 && dn_ready === 1'b1)
            cmp({dn_id, 1'b0, dn_prot, dn_atop, dn_op, 2'h0, |dn_stash,
                dn_snoop, dn_cache},
                q_dn.size() ? q_dn.pop_front() : 34'hx);
        if (done_valid === 1'b1 && done_ready === 1'b1)
            cmp({done_id, done_write, 14'h0, done_resp, 9'h0},
                q_done.size() ? q_done.pop_front() : 34'hx);
        if (fault_valid === 1'b1)
            cmp({10'h0, fault_sid},
                {10'h0, q_flt.size() ? q_flt.pop_front() : 24'hx});
        if (pf_valid === 1'b1)
            cmp({10'h0, pf_sid},
                {10'h0, q_pf.size() ? q_pf.pop_front() : 24'hx});
    end

    // main sequence
    initial
    begin
        int k;
        void'($urandom(34049));
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (k = 0; k < 16; k++) send(op_t'(k), 13'h1f3d);
        end_test("kinds kept");
        for (k = 0; k < 16; k++) send(op_t'(k), 13'h1800);
        end_test("kinds converted");
        for (k = 0; k < 16; k++) send(op_t'(k), 13'h113d);
        end_test("one permission");
        repeat (400) send(op_t'($urandom_range(0, 15)), 13'($urandom));
        end_test("random mix");
        test_done;
    end

    // cut a hang short
    initial
    begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        test_done;
    end
endmodule

`default_nettype wire
